//--- hdl/bpl_device.sv
// Sensor end of the BiPhase programming link
`timescale 1ns/1ns
module bpl_device
	import bpl_pkg::*;
#(
	parameter int REGS = 16,
	parameter int SYNC_CYC = SYNC_DET_CYC,
	parameter int TMAX_CYC = BIT_MAX_CYC,
	parameter int TMIN_CYC = BIT_MIN_CYC
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	bpl_link_if.dev link,
	input wire logic app_level_i,
	input wire logic [ANS_W-1:0] angle_i,
	input wire logic [$clog2(REGS)-1:0] cfg_addr_i,
	output logic [ANS_W-1:0] cfg_data_o,
	output logic prog_mode_o,
	output logic locked_o,
	output logic store_pulse_o
);
	localparam int IW = $clog2(REGS);
	if (REGS < 2 || REGS > 62 || SYNC_CYC <= TMAX_CYC || 2 * TMAX_CYC >= (1 << CW)
		|| SYNC_CYC >= (1 << CW) || TMIN_CYC < 4) begin : g_chk
		$error("bpl_device: parameter out of range");
	end
	localparam logic [CW-1:0] SYNC_L = CW'(SYNC_CYC - 1);
	localparam logic [CW-1:0] TMAX_L = CW'(TMAX_CYC);
	localparam logic [CW-1:0] TMIN_L = CW'(TMIN_CYC - 1);

	typedef enum logic [2:0] {
		S_APP, S_SYNC, S_IDLE, S_CAL, S_RX, S_TURN, S_TX
	} bpl_dst_t;

	bpl_dst_t st;
	logic [CW-1:0] cnt;
	logic [CW-1:0] tbit;
	logic line_q;
	logic half;
	logic [4:0] nbit;
	logic [TEL_W-1:0] sr;
	logic [ANS_W:0] tx_sr;
	logic drv;
	logic oe;
	logic exec;
	logic locked;
	logic [ANS_W-1:0] mem [REGS];
	logic [ANS_W-1:0] nvm [REGS];

	assign link.dev_out = drv;
	assign link.dev_oe = oe;

	// Line decode
	wire edge_w = link.line ^ line_q;
	wire [CW-1:0] th_long = tbit - (tbit >> 2);
	wire long_w = cnt >= th_long;
	wire [CW-1:0] th_half = tbit >> 1;
	wire rx_last = nbit == 5'(TEL_W - 1);
	wire tx_last = nbit == 5'(ANS_W + 1);
	wire contend = drv && !link.line;

	// Telegram fields
	wire [CMD_W-1:0] cmd_w = sr[CMD_LSB +: CMD_W];
	wire [ADDR_W-1:0] addr_w = sr[ADDR_LSB +: ADDR_W];
	wire [ANS_W-1:0] data_w = sr[DATA_LSB +: ANS_W];
	wire addr_ok = addr_w < ADDR_W'(REGS);
	wire lock_hit = addr_w == LOCK_ADDR;
	wire [ANS_W-1:0] rd_val = mem[addr_w[IW-1:0]];
	wire is_wr = cmd_w == BPL_CMD_WRITE;
	wire is_st = cmd_w == BPL_CMD_STORE;
	wire wr_ok = is_wr && !locked && addr_ok;
	wire lock_set = is_wr && !locked && lock_hit && data_w[0];
	wire st_ok = is_st && !locked;

	// Answer: angle, data, lock flag, acknowledge or error code
	wire [ANS_W-1:0] ans_read = lock_hit ? {15'h0000, locked} : addr_ok ? rd_val : ERR_ADDR;
	wire [ANS_W-1:0] ans_wr = locked ? ERR_LOCK : (addr_ok || lock_hit) ? ACK_CODE : ERR_ADDR;
	wire [ANS_W-1:0] ans_st = locked ? ERR_LOCK : ACK_CODE;
	wire [ANS_W-1:0] next_ans = (cmd_w == BPL_CMD_ANGLE) ? angle_i :
		(cmd_w == BPL_CMD_READ) ? ans_read :
		is_wr ? ans_wr : ans_st;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			line_q <= 1'b1;
		end else begin
			line_q <= link.line;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= S_APP;
			cnt <= '0;
			tbit <= TMAX_L;
			half <= 1'b0;
			nbit <= '0;
			sr <= '0;
			drv <= 1'b1;
			oe <= 1'b1;
			exec <= 1'b0;
		end else begin
			exec <= 1'b0;
			case (st)
				S_APP: begin
					drv <= app_level_i;
					// Only a low forced against our high level counts as sync
					cnt <= contend ? cnt + 1'b1 : '0;
					if (contend && cnt == SYNC_L) begin
						st <= S_SYNC;
						oe <= 1'b0;
						drv <= 1'b1;
					end
				end
				S_SYNC: begin
					// Waits for a settled high; swallows the release edge
					if (link.line && line_q) begin
						st <= S_IDLE;
					end
				end
				S_IDLE: begin
					cnt <= '0;
					if (edge_w) begin
						st <= S_CAL;
					end
				end
				S_CAL: begin
					// Leading 0 bit gives the host's bit time
					cnt <= cnt + 1'b1;
					if (edge_w) begin
						cnt <= '0;
						tbit <= cnt + 1'b1;
						half <= 1'b0;
						nbit <= '0;
						st <= (cnt >= TMIN_L) ? S_RX : S_IDLE;
					end else if (cnt >= TMAX_L) begin
						st <= S_IDLE;
					end
				end
				S_RX: begin
					cnt <= cnt + 1'b1;
					if (edge_w) begin
						cnt <= '0;
						if (long_w && half) begin
							st <= S_IDLE;
						end else if (long_w || half) begin
							// Long interval is a 0, two halves are a 1
							sr <= {sr[TEL_W-2:0], half};
							half <= 1'b0;
							nbit <= nbit + 1'b1;
							if (rx_last) begin
								st <= S_TURN;
								exec <= 1'b1;
							end
						end else begin
							half <= 1'b1;
						end
					end else if (cnt >= (tbit << 1)) begin
						// Missing boundary edge aborts the telegram
						st <= S_IDLE;
					end
				end
				S_TURN: begin
					cnt <= (link.line && line_q) ? cnt + 1'b1 : '0;
					if (cnt == tbit) begin
						st <= S_TX;
						cnt <= '0;
						nbit <= '0;
						oe <= 1'b1;
						drv <= 1'b1;
					end
				end
				S_TX: begin
					cnt <= (cnt == tbit - 1'b1) ? '0 : cnt + 1'b1;
					if (cnt == tbit - 1'b1) begin
						nbit <= nbit + 1'b1;
					end
					if (cnt == '0) begin
						drv <= ~drv;
					end else if (cnt == th_half) begin
						if (tx_last) begin
							st <= S_SYNC;
							oe <= 1'b0;
							drv <= 1'b1;
						end else if (tx_sr[ANS_W]) begin
							drv <= ~drv;
						end
					end
				end
				default: begin
					st <= S_APP;
				end
			endcase
		end
	end

	// Answer shifter: start bit 0 first, then MSB first
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_sr <= '0;
		end else if (exec) begin
			tx_sr <= {1'b0, next_ans};
		end else if (st == S_TX && cnt == tbit - 1'b1) begin
			tx_sr <= {tx_sr[ANS_W-1:0], 1'b0};
		end
	end

	// Register image and its stored copy
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < REGS; i++) begin
				mem[i] <= REG_RST;
				nvm[i] <= REG_RST;
			end
		end else if (exec && wr_ok) begin
			mem[addr_w[IW-1:0]] <= data_w;
		end else if (exec && st_ok) begin
			for (int i = 0; i < REGS; i++) begin
				nvm[i] <= mem[i];
			end
		end
	end

	// Lock is one-way; only reset clears it
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			locked <= 1'b0;
		end else if (exec && lock_set) begin
			locked <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prog_mode_o <= 1'b0;
			locked_o <= 1'b0;
			store_pulse_o <= 1'b0;
			cfg_data_o <= REG_RST;
		end else begin
			prog_mode_o <= st != S_APP;
			locked_o <= locked;
			store_pulse_o <= exec && st_ok;
			cfg_data_o <= nvm[cfg_addr_i];
		end
	end
endmodule

//--- common/bpl_pkg.sv
// Shared constants and types of the BiPhase programming link
package bpl_pkg;
	localparam int CLK_NS = 50;
	localparam int BIT_MIN_NS = 10000;
	localparam int BIT_MAX_NS = 1100000;
	localparam int BIT_MIN_CYC = (BIT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int BIT_MAX_CYC = BIT_MAX_NS / CLK_NS;
	localparam int SYNC_DET_NS = 2200000;
	localparam int SYNC_DET_CYC = SYNC_DET_NS / CLK_NS;
	localparam int SYNC_HOLD_NS = 2500000;
	localparam int SYNC_HOLD_CYC = SYNC_HOLD_NS / CLK_NS;
	localparam int HOST_BIT_NS = 50000;
	localparam int HOST_BIT_CYC = HOST_BIT_NS / CLK_NS;
	localparam int WAIT_BITS = 4;
	localparam int CW = 17;
	localparam int TEL_W = 24;
	localparam int ANS_W = 16;
	localparam int CMD_W = 2;
	localparam int ADDR_W = 6;
	localparam int CMD_LSB = 22;
	localparam int ADDR_LSB = 16;
	localparam int DATA_LSB = 0;
	localparam logic [ADDR_W-1:0] LOCK_ADDR = 6'h3e;
	localparam logic [ANS_W-1:0] ACK_CODE = 16'h00a5;
	localparam logic [ANS_W-1:0] ERR_LOCK = 16'h00e1;
	localparam logic [ANS_W-1:0] ERR_ADDR = 16'h00e2;
	localparam logic [ANS_W-1:0] REG_RST = 16'h0000;
	typedef enum logic [CMD_W-1:0] {
		BPL_CMD_ANGLE = 2'h0,
		BPL_CMD_READ = 2'h1,
		BPL_CMD_WRITE = 2'h2,
		BPL_CMD_STORE = 2'h3
	} bpl_cmd_t;
endpackage

//--- common/bpl_link_if.sv
// Shared programming pin: wired-AND of both drivers with pull-up
`timescale 1ns/1ns
interface bpl_link_if;
	logic dev_out;
	logic dev_oe;
	logic host_out;
	logic host_oe;
	logic line;
	assign line = (dev_oe ? dev_out : 1'b1) & (host_oe ? host_out : 1'b1);
	modport dev(output dev_out, output dev_oe, input line);
	modport host(output host_out, output host_oe, input line);
endinterface

//--- hdl/bpl_fifo.sv
// Telegram FIFO with valid/ready on both sides
`timescale 1ns/1ns
module bpl_fifo #(
	parameter int W = 24,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("bpl_fifo: DEPTH must be a power of two, at least 2");
	end
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr;
	logic [AW-1:0] rd;
	logic [AW:0] cnt;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;
	wire [AW:0] next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_o = mem[rd];
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr <= '0;
			rd <= '0;
			cnt <= '0;
			in_ready_o <= 1'b0;
			out_valid_o <= 1'b0;
		end else begin
			wr <= wr + AW'(push);
			rd <= rd + AW'(pop);
			cnt <= next_cnt;
			// Registered flags: full and empty follow the count exactly from the first clock after reset
			in_ready_o <= next_cnt != (AW+1)'(DEPTH);
			out_valid_o <= next_cnt != '0;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem[wr] <= in_data_i;
		end
	end
endmodule

//--- hdl/bpl_host.sv
// Programmer end of the BiPhase programming link
`timescale 1ns/1ns
module bpl_host
	import bpl_pkg::*;
#(
	parameter int BIT_CYC = HOST_BIT_CYC,
	parameter int SYNC_CYC = SYNC_HOLD_CYC,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	bpl_link_if.host link,
	input wire logic enter_i,
	input wire logic tel_valid_i,
	input wire logic [TEL_W-1:0] tel_data_i,
	output logic tel_ready_o,
	output logic ans_valid_o,
	output logic [ANS_W-1:0] ans_data_o,
	output logic ans_err_o
);
	// Bit time must stay in the device's accepted window
	if (BIT_CYC < BIT_MIN_CYC || BIT_CYC > BIT_MAX_CYC || SYNC_CYC >= (1 << CW)
		|| WAIT_BITS * BIT_CYC >= (1 << CW)) begin : g_chk
		$error("bpl_host: parameter out of range");
	end
	localparam logic [CW-1:0] T_L = CW'(BIT_CYC);
	localparam logic [CW-1:0] SYNC_L = CW'(SYNC_CYC - 1);
	localparam logic [CW-1:0] WAIT_L = CW'(WAIT_BITS * BIT_CYC);

	typedef enum logic [2:0] {
		H_IDLE, H_SYNC, H_TX, H_WAIT, H_RX, H_GAP
	} bpl_hst_t;

	bpl_hst_t st;
	logic [CW-1:0] cnt;
	logic [4:0] nbit;
	logic half;
	logic line_q;
	logic drv;
	logic oe;
	logic [TEL_W:0] sr;
	logic [CMD_W-1:0] cmd;
	logic f_valid;
	logic [TEL_W-1:0] f_data;

	assign link.host_out = drv;
	assign link.host_oe = oe;

	wire pop = st == H_IDLE && !enter_i && f_valid;
	wire edge_w = link.line ^ line_q;
	wire long_w = cnt >= T_L - (T_L >> 2);
	wire tx_last = nbit == 5'(TEL_W + 1);
	wire rx_last = nbit == 5'(ANS_W);
	wire needs_ack = cmd == BPL_CMD_WRITE || cmd == BPL_CMD_STORE;
	wire [ANS_W-1:0] rx_word = {sr[ANS_W-2:0], half};
	// Read answers, lock read-back included, pass through unchecked
	wire bad_ack = needs_ack && rx_word != ACK_CODE;

	// Queue lets software post read-back, lock, confirm in one go
	bpl_fifo #(.W(TEL_W), .DEPTH(DEPTH)) bpl_fifo_inst (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.in_valid_i(tel_valid_i),
		.in_data_i(tel_data_i),
		.in_ready_o(tel_ready_o),
		.out_valid_o(f_valid),
		.out_data_o(f_data),
		.out_ready_i(pop)
	);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= H_IDLE;
			cnt <= '0;
			nbit <= '0;
			half <= 1'b0;
			line_q <= 1'b1;
			drv <= 1'b1;
			oe <= 1'b0;
			sr <= '0;
			cmd <= BPL_CMD_ANGLE;
			ans_valid_o <= 1'b0;
			ans_data_o <= '0;
			ans_err_o <= 1'b0;
		end else begin
			line_q <= link.line;
			ans_valid_o <= 1'b0;
			case (st)
				H_IDLE: begin
					cnt <= '0;
					nbit <= '0;
					if (enter_i) begin
						st <= H_SYNC;
						oe <= 1'b1;
						drv <= 1'b0;
					end else if (f_valid) begin
						st <= H_TX;
						sr <= {1'b0, f_data};
						cmd <= f_data[CMD_LSB +: CMD_W];
						oe <= 1'b1;
						drv <= 1'b1;
					end
				end
				H_SYNC: begin
					cnt <= cnt + 1'b1;
					if (cnt == SYNC_L) begin
						st <= H_GAP;
						oe <= 1'b0;
						drv <= 1'b1;
					end
				end
				H_TX: begin
					cnt <= (cnt == T_L - 1'b1) ? '0 : cnt + 1'b1;
					if (cnt == T_L - 1'b1) begin
						nbit <= nbit + 1'b1;
						sr <= {sr[TEL_W-1:0], 1'b0};
					end
					if (cnt == '0) begin
						drv <= ~drv;
					end else if (cnt == (T_L >> 1)) begin
						if (tx_last) begin
							st <= H_WAIT;
							cnt <= '0;
							nbit <= '0;
							half <= 1'b0;
							oe <= 1'b0;
							drv <= 1'b1;
						end else if (sr[TEL_W]) begin
							drv <= ~drv;
						end
					end
				end
				H_WAIT: begin
					// Falling edge opens the answer; release edge is rising
					cnt <= cnt + 1'b1;
					if (edge_w && !link.line) begin
						st <= H_RX;
						cnt <= '0;
					end else if (cnt >= WAIT_L) begin
						st <= H_GAP;
						ans_valid_o <= 1'b1;
						ans_err_o <= 1'b1;
						ans_data_o <= '0;
					end
				end
				H_RX: begin
					cnt <= cnt + 1'b1;
					if (edge_w) begin
						cnt <= '0;
						if (long_w && half) begin
							st <= H_GAP;
							ans_valid_o <= 1'b1;
							ans_err_o <= 1'b1;
						end else if (long_w || half) begin
							sr <= {sr[TEL_W-1:0], half};
							half <= 1'b0;
							nbit <= nbit + 1'b1;
							if (rx_last) begin
								st <= H_GAP;
								ans_valid_o <= 1'b1;
								ans_data_o <= rx_word;
								ans_err_o <= bad_ack;
							end
						end else begin
							half <= 1'b1;
						end
					end else if (cnt >= (T_L << 1)) begin
						st <= H_GAP;
						ans_valid_o <= 1'b1;
						ans_err_o <= 1'b1;
					end
				end
				H_GAP: begin
					cnt <= (link.line && line_q) ? cnt + 1'b1 : '0;
					if (cnt == T_L) begin
						st <= H_IDLE;
					end
				end
				default: begin
					st <= H_IDLE;
				end
			endcase
		end
	end
endmodule

//--- tb/bpl_link_sva.sv
// Wire-level checks of the BiPhase programming link
`timescale 1ns/1ns
module bpl_link_sva #(
	parameter int BIT_CYC = 1000,
	parameter int HSYNC = 50000,
	parameter int DSYNC = 44000
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic host_out,
	input wire logic host_oe,
	input wire logic line
);
	logic line_q;
	logic h_all;
	logic d_all;
	logic seen_rel;
	int run;
	int low_cnt;
	int hlow;
	wire logic chg = line != line_q;
	wire logic sync_low = dev_oe & dev_out & ~line;
	wire logic host_low = host_oe & ~host_out;
	// Device timing comes from its own calibration, so allow a little slack
	wire logic dev_len_ok = (run >= BIT_CYC / 2 - 2 && run <= BIT_CYC / 2 + 2) ||
		(run >= BIT_CYC - 2 && run <= BIT_CYC + 2);
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			line_q <= 1'b1;
			run <= 0;
			seen_rel <= 1'b0;
		end else begin
			line_q <= line;
			run <= chg ? 1 : run + 1;
			seen_rel <= seen_rel | ~dev_oe;
		end
	end
	// Segment fully driven by one party; first segment after enable is skipped
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			h_all <= 1'b0;
			d_all <= 1'b0;
		end else begin
			h_all <= host_oe & (h_all | chg);
			d_all <= dev_oe & seen_rel & (d_all | chg);
		end
	end
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			low_cnt <= 0;
			hlow <= 0;
		end else begin
			low_cnt <= sync_low ? low_cnt + 1 : 0;
			hlow <= host_low ? hlow + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	a_reset_app_drive: assert property ($rose(nrst_i) |-> dev_oe && !host_oe)
		else $error("link not in application drive after reset");
	a_host_bit_len: assert property (chg && host_oe && h_all |->
		run == BIT_CYC || run == BIT_CYC / 2 || run == HSYNC)
		else $error("host bit segment has wrong length");
	a_dev_bit_len: assert property (chg && dev_oe && d_all |-> dev_len_ok)
		else $error("device bit segment has wrong length");
	a_dev_max_run: assert property (dev_oe && d_all |-> run <= BIT_CYC + 2)
		else $error("device bit period without closing edge");
	a_sync_release: assert property (low_cnt == DSYNC |-> ##[0:4] !dev_oe)
		else $error("device did not enter listen mode after sync");
	a_host_sync_len: assert property (hlow != 0 && !host_low |->
		hlow == HSYNC || hlow <= BIT_CYC)
		else $error("host low drive of wrong length");
	a_turn_gap: assert property ($fell(host_oe) |-> !dev_oe [*8])
		else $error("device answered without turnaround gap");
	a_no_contend: assert property (seen_rel && host_oe |-> !dev_oe)
		else $error("both ends drive the pin in programming mode");
	c_host_one: cover property (chg && host_oe && h_all && run == BIT_CYC / 2);
	c_dev_one: cover property (chg && dev_oe && d_all && dev_len_ok && run < BIT_CYC - 2);
	c_sync: cover property (low_cnt == DSYNC);
endmodule

//--- tb/test_biphase_programming_link.sv
// Self-checking bench joining programmer and sensor ends over one link
`timescale 1ns/1ns
module test_biphase_programming_link;
	import bpl_pkg::*;
	// Host bit time at the package minimum; sync must outlast the device's longest bit
	localparam int BIT = 200;
	localparam int DSYNC = 500;
	localparam int HSYNC = 600;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic app_level_i = 1'b1;
	logic enter_i = 1'b0;
	logic tel_valid_i = 1'b0;
	logic [TEL_W-1:0] tel_data_i = 24'h000000;
	logic [ANS_W-1:0] angle_i = 16'h1234;
	logic [3:0] cfg_addr_i = 4'h3;
	logic [ANS_W-1:0] cfg_data_o;
	logic [ANS_W-1:0] ans_data_o;
	logic prog_mode_o;
	logic locked_o;
	logic store_pulse_o;
	logic tel_ready_o;
	logic ans_valid_o;
	logic ans_err_o;
	int bad_count = 0;
	int num_checks = 0;
	int store_cnt = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (store_pulse_o === 1'b1) store_cnt <= store_cnt + 1;
	end
	bpl_link_if bpl_link_if_inst();
	bpl_device #(.SYNC_CYC(DSYNC), .TMAX_CYC(2 * BIT), .TMIN_CYC(8)) bpl_device_inst (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(bpl_link_if_inst),
		.app_level_i(app_level_i), .angle_i(angle_i), .cfg_addr_i(cfg_addr_i),
		.cfg_data_o(cfg_data_o), .prog_mode_o(prog_mode_o), .locked_o(locked_o),
		.store_pulse_o(store_pulse_o));
	bpl_host #(.BIT_CYC(BIT), .SYNC_CYC(HSYNC), .DEPTH(4)) bpl_host_inst (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(bpl_link_if_inst), .enter_i(enter_i),
		.tel_valid_i(tel_valid_i), .tel_data_i(tel_data_i), .tel_ready_o(tel_ready_o),
		.ans_valid_o(ans_valid_o), .ans_data_o(ans_data_o), .ans_err_o(ans_err_o));
	bpl_link_sva #(.BIT_CYC(BIT), .HSYNC(HSYNC), .DSYNC(DSYNC)) bpl_link_sva_inst (
		.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .dev_out(bpl_link_if_inst.dev_out),
		.dev_oe(bpl_link_if_inst.dev_oe), .host_out(bpl_link_if_inst.host_out),
		.host_oe(bpl_link_if_inst.host_oe), .line(bpl_link_if_inst.line));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic give_up(input string what);
		bad_count++;
		$display("FAIL %s expected done seen timeout", what);
		tally_and_finish();
	endtask
	function automatic logic [TEL_W-1:0] tel(input bpl_cmd_t c, input logic [ADDR_W-1:0] a,
		input logic [15:0] d);
		return {c, a, d};
	endfunction
	// Caller holds valid; data is taken at the edge where ready is high
	task automatic push(input logic [TEL_W-1:0] t);
		int n;
		n = 0;
		tel_data_i = t;
		while (tel_ready_o !== 1'b1) begin
			if (n > 40 * BIT) give_up("fifo ready");
			n++;
			tick(1);
		end
		tick(1);
	endtask
	task automatic expect_ans(input string what, input logic [ANS_W-1:0] d, input logic e);
		int n;
		n = 0;
		while (ans_valid_o !== 1'b1) begin
			if (n > 60 * BIT) give_up(what);
			n++;
			tick(1);
		end
		check(what, ans_data_o, d);
		check("answer error flag", ans_err_o, e);
		tick(1);
	endtask
	task automatic sc_app_mode();
		check("mode after reset", prog_mode_o, 1'b0);
		check("device drives pin", bpl_link_if_inst.dev_oe, 1'b1);
		app_level_i = 1'b0;
		tick(2);
		check("pin follows low level", bpl_link_if_inst.line, 1'b0);
		app_level_i = 1'b1;
		tick(2);
		check("pin follows high level", bpl_link_if_inst.line, 1'b1);
		check("no mode from own low", prog_mode_o, 1'b0);
	endtask
	task automatic sc_enter();
		int n;
		n = 0;
		enter_i = 1'b1;
		tick(1);
		enter_i = 1'b0;
		while (prog_mode_o !== 1'b1) begin
			if (n > 2 * HSYNC) give_up("sync entry");
			n++;
			tick(1);
		end
		check("sync length", n >= DSYNC - 2 && n <= DSYNC + 8, 1'b1);
		n = 0;
		while (bpl_link_if_inst.host_oe !== 1'b0) begin
			if (n > 2 * HSYNC) give_up("sync release");
			n++;
			tick(1);
		end
		tick(2 * BIT);
		check("device listens", bpl_link_if_inst.dev_oe, 1'b0);
	endtask
	task automatic sc_program();
		tel_valid_i = 1'b1;
		push(tel(BPL_CMD_WRITE, 6'h03, 16'h5a3c));
		push(tel(BPL_CMD_STORE, 6'h00, 16'h0000));
		push(tel(BPL_CMD_READ, 6'h03, 16'h0000));
		push(tel(BPL_CMD_ANGLE, 6'h00, 16'h0000));
		push(tel(BPL_CMD_READ, 6'h20, 16'h0000));
		tel_valid_i = 1'b0;
		expect_ans("write answer", ACK_CODE, 1'b0);
		expect_ans("store answer", ACK_CODE, 1'b0);
		expect_ans("read answer", 16'h5a3c, 1'b0);
		expect_ans("angle answer", 16'h1234, 1'b0);
		expect_ans("unmapped read", ERR_ADDR, 1'b0);
		check("store pulses", store_cnt, 32'h1);
		check("stored setting", cfg_data_o, 16'h5a3c);
	endtask
	// Five back-to-back pushes: one in flight, four fill the queue
	task automatic sc_lock();
		tel_valid_i = 1'b1;
		push(tel(BPL_CMD_WRITE, LOCK_ADDR, 16'h0001));
		push(tel(BPL_CMD_READ, LOCK_ADDR, 16'h0000));
		push(tel(BPL_CMD_WRITE, 6'h03, 16'h0000));
		push(tel(BPL_CMD_STORE, 6'h00, 16'h0000));
		push(tel(BPL_CMD_READ, 6'h03, 16'h0000));
		tel_valid_i = 1'b0;
		tick(1);
		check("fifo full", tel_ready_o, 1'b0);
		expect_ans("lock answer", ACK_CODE, 1'b0);
		check("lock flag", locked_o, 1'b1);
		expect_ans("lock readback", 16'h0001, 1'b0);
		expect_ans("locked write", ERR_LOCK, 1'b1);
		expect_ans("locked store", ERR_LOCK, 1'b1);
		expect_ans("locked read", 16'h5a3c, 1'b0);
		check("store pulses", store_cnt, 32'h1);
		check("setting kept", cfg_data_o, 16'h5a3c);
		check("fifo drained", tel_ready_o, 1'b1);
	endtask
	initial begin
		tick(2);
		nrst_i = 1'b1;
		tick(2);
		sc_app_mode();
		sc_enter();
		sc_program();
		sc_lock();
		tally_and_finish();
	end
endmodule
